//--- hdl/byte_fifo2.sv
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module byte_fifo2 import rtcc_i2c_pkg::*; #(
   parameter int W = BUF_WIDTH,
   parameter int D = BUF_DEPTH
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   // sized one bit wider than the pointers so that a full count of D is not lost
   localparam logic [AW:0] FULL_CNT = (AW+1)'(D);
   localparam logic [AW-1:0] LAST_PTR = AW'(D - 1);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } fifo_s;

   fifo_s q, d;
   logic push, pop;

   assign in_ready = (q.cnt != FULL_CNT);
   assign out_valid = (q.cnt != '0);
   assign out_data = q.mem[q.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wp] = in_data;
         d.wp = (q.wp == LAST_PTR) ? '0 : q.wp + AW'(1);
      end
      if (pop) begin
         d.rp = (q.rp == LAST_PTR) ? '0 : q.rp + AW'(1);
      end
      d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   fifo_no_overflow_a: assert property (q.cnt == FULL_CNT |-> !in_ready)
      else $error("buffer offers room while full");
   fifo_keeps_word_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("stalled word changed or vanished");
endmodule : byte_fifo2
`default_nettype wire

//--- hdl/rtcc_i2c_slave.sv
// two-wire serial slave front end of the real-time clock
`timescale 1ns/1ps
`default_nettype none
module rtcc_i2c_slave import rtcc_i2c_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // serial pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // power and nonvolatile status
   input wire logic on_backup_supply,
   input wire logic eeprom_programming,
   // received bytes
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [7:0] rx_data,
   output logic [7:0] rx_reg_addr,
   output logic rx_eeprom_space,
   // bytes to send
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data,
   // multifunction output
   input wire logic mfp_square_wave_en,
   input wire logic mfp_square_wave,
   input wire logic mfp_alarm_en,
   input wire logic mfp_alarm_level,
   input wire logic mfp_out_level,
   output logic multifunction_output_pin_out,
   output logic multifunction_output_pin_oe,
   // timebase
   input wire logic ext_osc_en,
   input wire logic crystal_or_clock_input_pin,
   input wire logic crystal_osc_tick,
   output logic timebase_tick
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_p;
      logic sda_s1;
      logic sda_s2;
      logic sda_p;
      logic bak_s1;
      logic bak_s2;
      logic x1_s1;
      logic x1_s2;
      logic x1_p;
      link_st_e st;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic [7:0] txsh;
      logic is_eeprom;
      logic is_read;
      logic addr_phase;
      logic acked;
      logic master_nack;
      logic drive;
      logic push;
      logic [7:0] reg_addr;
      logic mfp_oe;
      logic tick;
   } slave_s;

   slave_s q, d;
   logic rise, fall, start_c, stop_c;
   logic buf_in_ready;
   logic load_tx;
   logic [1:0] match_c;

   // ----------------------------------------
   // bus conditions
   // ----------------------------------------
   assign rise = q.scl_s2 && !q.scl_p;
   assign fall = !q.scl_s2 && q.scl_p;
   assign start_c = q.scl_s2 && q.scl_p && q.sda_p && !q.sda_s2;
   assign stop_c = q.scl_s2 && q.scl_p && !q.sda_p && q.sda_s2;
   assign match_c = ctrl_match(q.shreg);

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      d = q;
      load_tx = 1'b0;
      d.scl_s1 = scl_in;
      d.scl_s2 = q.scl_s1;
      d.scl_p = q.scl_s2;
      d.sda_s1 = sda_in;
      d.sda_s2 = q.sda_s1;
      d.sda_p = q.sda_s2;
      d.bak_s1 = on_backup_supply;
      d.bak_s2 = q.bak_s1;
      d.x1_s1 = crystal_or_clock_input_pin;
      d.x1_s2 = q.x1_s1;
      d.x1_p = q.x1_s2;
      d.push = 1'b0;

      if (q.bak_s2) begin
         d.st = ST_IDLE;
         d.drive = 1'b0;
      end else if (start_c) begin
         d.st = ST_ADDR;
         d.bitcnt = BIT_ZERO;
         d.drive = 1'b0;
      end else if (stop_c) begin
         d.st = ST_IDLE;
         d.drive = 1'b0;
      end else begin
         case (q.st)
            ST_ADDR, ST_WR_BYTE: begin
               if (rise) begin
                  d.shreg = {q.shreg[6:0], q.sda_s2};
                  d.bitcnt = q.bitcnt + BIT_ONE;
               end else if (fall && q.bitcnt == BITS_PER_BYTE) begin
                  if (q.st == ST_ADDR) begin
                     d.is_eeprom = match_c[0];
                     d.is_read = q.shreg[RW_BIT];
                     d.addr_phase = !q.shreg[RW_BIT];
                     if (match_c[1] || (match_c[0] && !eeprom_programming)) begin
                        d.drive = 1'b1;
                        d.st = ST_ADDR_ACK;
                     end else begin
                        d.drive = 1'b0;
                        d.st = ST_IGNORE;
                     end
                  end else begin
                     if (q.addr_phase) begin
                        d.acked = addr_ok(q.is_eeprom, q.shreg);
                        d.reg_addr = q.shreg;
                        d.addr_phase = 1'b0;
                     end else begin
                        d.acked = buf_in_ready;
                        d.push = buf_in_ready;
                     end
                     d.drive = d.acked;
                     d.st = ST_WR_ACK;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (fall) begin
                  d.bitcnt = BIT_ZERO;
                  if (q.is_read) begin
                     load_tx = 1'b1;
                     d.txsh = tx_valid ? tx_data : IDLE_BYTE;
                     d.drive = !d.txsh[7];
                     d.st = ST_RD_BYTE;
                  end else begin
                     d.drive = 1'b0;
                     d.st = ST_WR_BYTE;
                  end
               end
            end
            ST_WR_ACK: begin
               if (fall) begin
                  d.drive = 1'b0;
                  d.bitcnt = BIT_ZERO;
                  d.st = q.acked ? ST_WR_BYTE : ST_IGNORE;
               end
            end
            ST_RD_BYTE: begin
               if (rise) begin
                  d.bitcnt = q.bitcnt + BIT_ONE;
               end else if (fall) begin
                  if (q.bitcnt == BITS_PER_BYTE) begin
                     d.drive = 1'b0;
                     d.st = ST_RD_ACK;
                  end else begin
                     d.txsh = {q.txsh[6:0], 1'b1};
                     d.drive = !d.txsh[7];
                  end
               end
            end
            ST_RD_ACK: begin
               if (rise) begin
                  d.master_nack = q.sda_s2;
               end else if (fall) begin
                  d.bitcnt = BIT_ZERO;
                  if (q.master_nack) begin
                     d.drive = 1'b0;
                     d.st = ST_IGNORE;
                  end else begin
                     load_tx = 1'b1;
                     d.txsh = tx_valid ? tx_data : IDLE_BYTE;
                     d.drive = !d.txsh[7];
                     d.st = ST_RD_BYTE;
                  end
               end
            end
            ST_IGNORE: begin
               d.drive = 1'b0;
            end
            default: begin
               d.drive = 1'b0;
            end
         endcase
      end

      // multifunction pin: open drain, pulls low for a low level
      if (mfp_square_wave_en) begin
         d.mfp_oe = !mfp_square_wave;
      end else if (mfp_alarm_en) begin
         d.mfp_oe = !mfp_alarm_level;
      end else begin
         d.mfp_oe = !mfp_out_level;
      end

      // timebase: rising edge of clock input or crystal oscillator tick
      d.tick = ext_osc_en ? (q.x1_s2 && !q.x1_p) : crystal_osc_tick;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= '0;
         q.scl_s1 <= 1'b1;
         q.scl_s2 <= 1'b1;
         q.scl_p <= 1'b1;
         q.sda_s1 <= 1'b1;
         q.sda_s2 <= 1'b1;
         q.sda_p <= 1'b1;
         q.st <= ST_IDLE;
         q.txsh <= IDLE_BYTE;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // receive buffer
   // ----------------------------------------
   byte_fifo2 #(
      .W(BUF_WIDTH),
      .D(BUF_DEPTH)
   ) u_rx_buf (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(q.push),
      .in_ready(buf_in_ready),
      .in_data(q.shreg),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_data)
   );

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign sda_out = 1'b0;
   assign sda_oe = q.drive;
   assign tx_ready = load_tx;
   assign rx_reg_addr = q.reg_addr;
   assign rx_eeprom_space = q.is_eeprom;
   assign multifunction_output_pin_out = 1'b0;
   assign multifunction_output_pin_oe = q.mfp_oe;
   assign timebase_tick = q.tick;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence ctrl_byte_done;
      q.st == ST_ADDR && fall && q.bitcnt == BITS_PER_BYTE && !q.bak_s2;
   endsequence

   sequence read_nack_seen;
      q.st == ST_RD_ACK && fall && q.master_nack && !q.bak_s2 && !start_c && !stop_c;
   endsequence

   start_detect_a: assert property (start_c && !q.bak_s2 |=> q.st == ST_ADDR && !q.drive)
      else $error("start not taken");
   stop_detect_a: assert property (stop_c && !q.bak_s2 |=> q.st == ST_IDLE && !sda_oe)
      else $error("stop not taken");
   backup_quiet_a: assert property (q.bak_s2 |=> !sda_oe && q.st == ST_IDLE)
      else $error("bus served on backup supply");
   drive_on_low_a: assert property ($rose(sda_oe) |-> $past(fall) && !q.scl_s2)
      else $error("sda pulled outside the scl low phase");
   ctrl_ack_a: assert property (ctrl_byte_done ##0 match_c[1] |=> sda_oe [*2])
      else $error("register space control byte not acked");
   ee_busy_nack_a: assert property (
      ctrl_byte_done ##0 (match_c[0] && eeprom_programming) |=> !sda_oe && q.st == ST_IGNORE)
      else $error("eeprom acked while programming");
   foreign_quiet_a: assert property (q.st == ST_IGNORE |-> !sda_oe)
      else $error("sda driven after foreign address");
   read_release_a: assert property (read_nack_seen |=> !sda_oe && q.st == ST_IGNORE)
      else $error("sda held after master nack");
   range_nack_a: assert property (
      q.st == ST_WR_BYTE && q.addr_phase && fall && q.bitcnt == BITS_PER_BYTE && !q.bak_s2
      && !start_c && !stop_c && !addr_ok(q.is_eeprom, q.shreg) |=> !sda_oe)
      else $error("out of range address acked");
   ack_hold_a: assert property (q.st == ST_ADDR_ACK && rise |-> sda_oe)
      else $error("ack not low at the ack clock high phase");
endmodule : rtcc_i2c_slave
`default_nettype wire

//--- pkg/rtcc_i2c_pkg.sv
// constants, types and decode helpers for the two-wire slave interface
package rtcc_i2c_pkg;

   // ----------------------------------------
   // control byte layout
   // ----------------------------------------
   localparam logic [3:0] CODE_EEPROM = 4'hA;
   localparam logic [3:0] CODE_RTCC = 4'hD;
   localparam logic [2:0] CHIP_SEL = 3'h7;
   localparam int CODE_MSB = 7;
   localparam int CODE_LSB = 4;
   localparam int CS_MSB = 3;
   localparam int CS_LSB = 1;
   localparam int RW_BIT = 0;

   // ----------------------------------------
   // implemented address ranges
   // ----------------------------------------
   localparam logic [7:0] RTCC_ADDR_LO = 8'h00;
   localparam logic [7:0] RTCC_ADDR_HI = 8'h5F;
   localparam logic [7:0] EE_ADDR_LO = 8'hF0;
   localparam logic [7:0] EE_ADDR_HI = 8'hF7;

   // ----------------------------------------
   // framing and buffering
   // ----------------------------------------
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] BIT_ZERO = 4'h0;
   localparam logic [3:0] BIT_ONE = 4'h1;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam int BUF_WIDTH = 8;
   localparam int BUF_DEPTH = 2;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK, ST_RD_BYTE, ST_RD_ACK, ST_IGNORE
   } link_st_e;

   // control byte decode: bit 1 = register/sram space, bit 0 = eeprom space
   function automatic logic [1:0] ctrl_match(input logic [7:0] b);
      logic cs_ok;
      cs_ok = (b[CS_MSB:CS_LSB] == CHIP_SEL);
      ctrl_match = {cs_ok && (b[CODE_MSB:CODE_LSB] == CODE_RTCC),
                    cs_ok && (b[CODE_MSB:CODE_LSB] == CODE_EEPROM)};
   endfunction : ctrl_match

   // register address inside the implemented part of the selected space
   function automatic logic addr_ok(input logic eeprom, input logic [7:0] a);
      addr_ok = eeprom ? (a >= EE_ADDR_LO && a <= EE_ADDR_HI)
                       : (a >= RTCC_ADDR_LO && a <= RTCC_ADDR_HI);
   endfunction : addr_ok

endpackage : rtcc_i2c_pkg

//--- verification/i2c_master_model.sv
// two-wire bus master model that drives scl and pulls sda
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
   // bus lines
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   event got;
   logic [7:0] got_val;
   logic r;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // -------------------------------
   // conditions
   // -------------------------------
   // entered from idle or just after an scl fall
   task automatic start;
      #60 sda_low = 1'b0;
      #140 scl = 1'b1;
      #60 sda_low = 1'b1;
      #60 scl = 1'b0;
   endtask : start
   // leaves the bus idle with both lines high
   task automatic stop;
      #60 sda_low = 1'b1;
      #140 scl = 1'b1;
      #60 sda_low = 1'b0;
      #200;
   endtask : stop
   // -------------------------------
   // bits and bytes
   // -------------------------------
   // data moves only in the low phase, sampled at the end of the high phase
   task automatic bitx(input logic b, output logic v);
      #60 sda_low = !b;
      #140 scl = 1'b1;
      #120 v = sda;
      scl = 1'b0;
   endtask : bitx
   task automatic wr_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) bitx(b[i], r);
      bitx(1'b1, r);
      got_val = {7'h00, !r};
      -> got;
   endtask : wr_byte
   // ack keeps the read going, nack ends it
   task automatic rd_byte(input logic ack);
      for (int i = 7; i >= 0; i--) bitx(1'b1, got_val[i]);
      bitx(!ack, r);
      -> got;
   endtask : rd_byte
endmodule : i2c_master_model
`default_nettype wire

//--- verification/testbench.sv
// self-checking bench for the two-wire slave front end
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic on_backup_supply = 1'b0;
   logic eeprom_programming = 1'b0;
   logic rx_ready = 1'b0, stall = 1'b0, tx_valid = 1'b0;
   logic [7:0] tx_data = 8'h00;
   logic [4:0] mf = 5'h00;
   logic ext_osc_en = 1'b0, xtal = 1'b0, osc_tick = 1'b0;
   logic scl, sda_low, sda_oe, sda_out, rx_valid, tx_ready, mfp_oe, tick, v, rx_eeprom_space;
   logic [7:0] rx_data, rx_reg_addr, d;
   wire logic sda;
   int bad_count = 0, cmp_count = 0, cyc = 0, ticks = 0;
   logic [7:0] rx_q[$], lk_q[$];
   // {control byte, address byte, programming, control ack, address ack}
   logic [18:0] tbl [0:10] = '{
      {8'hDE, 8'h5F, 3'h3}, {8'hDE, 8'h60, 3'h2}, {8'hAE, 8'hF0, 3'h3}, {8'hAE, 8'hF7, 3'h3},
      {8'hAE, 8'hF8, 3'h2}, {8'hAE, 8'hEF, 3'h2}, {8'hAE, 8'hF0, 3'h4}, {8'hDE, 8'h00, 3'h7},
      {8'hDC, 8'h00, 3'h0}, {8'h5E, 8'h00, 3'h0}, {8'hFE, 8'h00, 3'h0}};

   // wired-and data line with pull-up
   assign sda = (sda_oe ? sda_out : 1'b1) & !sda_low;
   always #20 clk = ~clk;

   rtcc_i2c_slave dut_u (
      .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .on_backup_supply(on_backup_supply),
      .eeprom_programming(eeprom_programming), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_data(rx_data), .rx_reg_addr(rx_reg_addr), .rx_eeprom_space(rx_eeprom_space),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
      .mfp_square_wave_en(mf[4]), .mfp_square_wave(mf[3]), .mfp_alarm_en(mf[2]),
      .mfp_alarm_level(mf[1]), .mfp_out_level(mf[0]), .multifunction_output_pin_out(),
      .multifunction_output_pin_oe(mfp_oe), .ext_osc_en(ext_osc_en),
      .crystal_or_clock_input_pin(xtal), .crystal_osc_tick(osc_tick), .timebase_tick(tick)
   );
   i2c_master_model m_u (.scl(scl), .sda_low(sda_low), .sda(sda));

   // -------------------------------
   // helpers
   // -------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic next_clk;
      @(posedge clk);
      #1;
   endtask : next_clk
   task automatic wb(input logic [7:0] b, input logic a);
      lk_q.push_back({7'h00, a});
      m_u.wr_byte(b);
   endtask : wb
   task automatic rb(input logic [7:0] e, input logic a);
      lk_q.push_back(e);
      m_u.rd_byte(a);
   endtask : rb
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results

   // -------------------------------
   // monitors and timeout
   // -------------------------------
   always @(m_u.got) chk(m_u.got_val, lk_q.pop_front());
   always @(posedge clk) if (rx_valid === 1'b1 && rx_ready === 1'b1) chk(rx_data, rx_q.pop_front());
   always @(posedge clk) rx_ready <= #1 !stall && 1'($urandom);
   always @(posedge clk) if (tx_ready === 1'b1) tx_valid <= #1 1'b0;
   always @(posedge clk) if (tick === 1'b1) ticks <= ticks + 1;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         results();
      end
   end

   // -------------------------------
   // scenarios
   // -------------------------------
   initial begin
      void'($urandom(32'h112b));
      repeat (3) @(posedge clk);
      sys_rst <= #1 1'b0;
      repeat (4) next_clk();
      // stalled receiver: two words buffered, third refused
      stall = 1'b1;
      m_u.start();
      wb(8'hDE, 1'b1);
      wb(8'h05, 1'b1);
      for (int i = 0; i < 3; i++) begin
         d = 8'($urandom);
         if (i < 2) rx_q.push_back(d);
         wb(d, i < 2);
      end
      m_u.stop();
      chk(rx_reg_addr, 8'h05);
      stall = 1'b0;
      repeat (30) next_clk();
      chk(8'(rx_q.size()), 8'h00);
      // address table, first entry opened by a start inside a cut byte
      m_u.start();
      m_u.bitx(1'b1, v);
      m_u.bitx(1'b0, v);
      for (int i = 0; i < 11; i++) begin
         next_clk();
         eeprom_programming = tbl[i][2];
         m_u.start();
         wb(tbl[i][18:11], tbl[i][1]);
         wb(tbl[i][10:3], tbl[i][0]);
         if (tbl[i][0]) chk(rx_reg_addr, tbl[i][10:3]);
         if (tbl[i][1]) chk({7'h00, rx_eeprom_space}, {7'h00, tbl[i][18:11] == 8'hAE});
         if (i[0]) m_u.stop();
      end
      m_u.stop();
      // read: one byte from the source, then filler, then nack
      next_clk();
      eeprom_programming = 1'b0;
      tx_data = 8'($urandom);
      tx_valid = 1'b1;
      m_u.start();
      wb(8'hDF, 1'b1);
      rb(tx_data, 1'b1);
      rb(8'hFF, 1'b0);
      wb(8'h00, 1'b0);
      m_u.stop();
      // backup supply: bus ignored, then served again
      next_clk();
      on_backup_supply = 1'b1;
      repeat (4) next_clk();
      m_u.start();
      wb(8'hDE, 1'b0);
      m_u.stop();
      next_clk();
      on_backup_supply = 1'b0;
      repeat (4) next_clk();
      m_u.start();
      wb(8'hDE, 1'b1);
      m_u.stop();
      // multifunction pin sources
      for (int i = 0; i < 16; i++) begin
         next_clk();
         mf = 5'($urandom);
         repeat (3) next_clk();
         chk({7'h00, mfp_oe}, {7'h00, !(mf[4] ? mf[3] : mf[2] ? mf[1] : mf[0])});
      end
      // timebase from the crystal pin, then from the internal oscillator
      ext_osc_en = 1'b1;
      repeat (4) next_clk();
      ticks = 0;
      repeat (4) begin
         #190 xtal = 1'b1;
         #190 xtal = 1'b0;
      end
      repeat (6) next_clk();
      chk(8'(ticks), 8'h04);
      ext_osc_en = 1'b0;
      repeat (4) next_clk();
      ticks = 0;
      repeat (3) begin
         next_clk();
         osc_tick = 1'b1;
         next_clk();
         osc_tick = 1'b0;
      end
      repeat (6) next_clk();
      chk(8'(ticks), 8'h03);
      results();
   end
endmodule : testbench
`default_nettype wire
